// file: pkg/clock_mode_cfg.svh
// Offsets, field positions, reset values and tick fractions
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH

`define CFG_WORD_MODE_MSB   31
`define CFG_WORD_MODE_LSB   28

`define REG_CLOCK_CTRL      4'h0
`define REG_MODE            4'h4
`define REG_FACTORS         4'h8
`define REG_RATIO           4'hc

`define CLOCK_CTRL_RESET    4'h3

`define MODE_CODE_LSB       0
`define MODE_RANGE_BIT      8
`define MODE_VALID_BIT      9
`define MODE_LOADED_BIT     10

`define FACT_COMM_LSB       0
`define FACT_CORE_LSB       8
`define FACT_PDIV_LSB       16

`define RATIO_LSB           0
`define RATIO_VALID_BIT     8

`define REF_DIV_DEFAULT     140
`define REF_DIV_GRAIN       140
`define REF_DIV_MAX         65535

`define CORE_X2_2P5         5'h05
`define CORE_X2_3P5         5'h07

`define TICK_Q_SECOND_NUM   1
`define TICK_Q_FOURTH_NUM   3
`define TICK_Q_DEN          4
`define TICK_T_SECOND_NUM   3
`define TICK_T_FOURTH_NUM   8
`define TICK_T_DEN          10
`define TICK_F_SECOND_NUM   4
`define TICK_F_FOURTH_NUM   11
`define TICK_F_DEN          14
`define TICK_THIRD_NUM      1
`define TICK_THIRD_DEN      2

`endif

// file: pkg/clock_mode_pkg.sv
// Types shared by the clock mode decoder
package clock_mode_pkg;

  typedef enum logic [1:0] {
    SPACE_QUARTER,
    SPACE_TENTH,
    SPACE_FOURTEENTH
  } tick_spacing_e;

  // Multipliers are held in half steps: value 5 means 2.5
  typedef struct packed {
    logic       valid;
    logic [4:0] comm_x2;
    logic [4:0] core_x2;
    logic [3:0] pci_div;
  } clk_setting_s;

  typedef struct packed {
    logic          loaded;
    logic          range;
    logic [6:0]    code;
    clk_setting_s  cfg;
    logic          reserved;
    tick_spacing_e spacing;
    logic [3:0]    div_field;
    logic          ratio_valid;
    logic [4:0]    ratio_x2;
    logic [15:0]   cnt;
    logic          first;
    logic          second;
    logic          third;
    logic          fourth;
    logic          bus_launch;
    logic          mem_tick;
    logic [31:0]   rdata;
  } state_s;

endpackage

// file: src/clock_mode_decode_and_ticks.sv
// Clock mode decoder, PCI ratio and memory controller tick generator
`timescale 1ns/10ps
`include "clock_mode_cfg.svh"

// What this block does
// - Mode code is config word bits 28-31 above three config pins.
// - Comm processor multiplier is its clock over bus clock.
// - Core multiplier is applied directly as core PLL factor.
// - Range select picks table: 0 up to 66.7 MHz, 1 up to 50.0.
// - Range 0: processor-to-PCI ratio is division field plus one, halved.
// - Range 1: field 3,5,7,9,B map to ratio 4,6,8,5,6.
// - Range 0 default codes 0000_000 and 0000_001 decode as listed.
// - Range 0 codes 0001_000..011: comm 3, core 5..8, PCI 3.
// - Range 0 codes 0010_000..110: comm 4, core 5..8 div 4, 5..6 div 6.
// - Range 0 codes 0011_000..011: comm 5, core 5..8, PCI 5.
// - Range 0 codes 1101_000..110: comm 2.5 or 2, PCI 5.
// - Range 0 codes 1110_000..100: comm 3, core 3.5..5.5, PCI 6.
// - Range 1 codes 1000_010..110: comm 3, core 3.5..6.5, PCI 8.
// - Range 1 codes 1010_xxx: comm 2, PCI 6 or 8.
// - Bus outputs launch only at reference clock rising edge.
// - Four ticks per reference cycle; memory outputs move on any.
// - First tick at rising edge, third tick at falling edge.
// - Integer ratios: second tick at 1/4, fourth at 3/4.
// - Ratio 2.5: second tick at 3/10, fourth at 8/10.
// - Ratio 3.5: second tick at 4/14, fourth at 11/14.
module clock_mode_decode_and_ticks #(
  parameter int REF_DIV = `REF_DIV_DEFAULT
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [31:0] hard_reset_config_word,
  input  wire logic [2:0]  mode_config_pins,
  input  wire logic        pci_range_select,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  output logic             first_tick,
  output logic             second_tick,
  output logic             third_tick,
  output logic             fourth_tick,
  output logic             bus_launch,
  output logic             mem_tick,
  output logic      [4:0]  comm_proc_mult_x2,
  output logic      [4:0]  core_mult_x2,
  output logic      [3:0]  pci_div,
  output logic             mode_reserved,
  output logic             config_loaded,
  output logic      [4:0]  pci_ratio_x2,
  output logic             pci_ratio_valid
);

  // Tick positions in system clock cycles within one reference period
  localparam int LAST  = REF_DIV - 1;
  localparam int HALF  = REF_DIV * `TICK_THIRD_NUM / `TICK_THIRD_DEN;
  localparam int Q2    = REF_DIV * `TICK_Q_SECOND_NUM / `TICK_Q_DEN;
  localparam int Q4    = REF_DIV * `TICK_Q_FOURTH_NUM / `TICK_Q_DEN;
  localparam int D2    = REF_DIV * `TICK_T_SECOND_NUM / `TICK_T_DEN;
  localparam int D4    = REF_DIV * `TICK_T_FOURTH_NUM / `TICK_T_DEN;
  localparam int F2    = REF_DIV * `TICK_F_SECOND_NUM / `TICK_F_DEN;
  localparam int F4    = REF_DIV * `TICK_F_FOURTH_NUM / `TICK_F_DEN;

  // Exact fractions need a period that all three denominators divide
  generate
    if (REF_DIV < `REF_DIV_GRAIN || REF_DIV > `REF_DIV_MAX ||
        (REF_DIV % `REF_DIV_GRAIN) != 0) begin : g_bad_div
      $error("REF_DIV must be a multiple of 140 below 65536");
    end
  endgenerate

  clock_mode_pkg::state_s q;
  clock_mode_pkg::state_s next_q;

  function automatic clock_mode_pkg::clk_setting_s decode_mode(
    input logic       range,
    input logic [6:0] code
  );
    clock_mode_pkg::clk_setting_s s;
    logic [2:0] lo;
    logic [4:0] k;
    s  = '0;
    lo = code[2:0];
    k  = {2'b00, lo};
    if (!range) begin
      case (code[6:3])
        4'h0: begin
          if (lo == 3'h0)
            s = '{1'b1, 5'h04, 5'h05, 4'h2};
          else if (lo == 3'h1)
            s = '{1'b1, 5'h04, 5'h06, 4'h2};
        end
        4'h1: begin
          if (!lo[2])
            s = '{1'b1, 5'h06, 5'(5'h0a + (k << 1)), 4'h3};
        end
        // comm 4, PCI 4 or 6
        4'h2: begin
          if (!lo[2])
            s = '{1'b1, 5'h08, 5'(5'h0a + (k << 1)), 4'h4};
          else if (lo != 3'h7)
            s = '{1'b1, 5'h08, 5'(5'h06 + k), 4'h6};
        end
        4'h3: begin
          if (!lo[2])
            s = '{1'b1, 5'h0a, 5'(5'h0a + (k << 1)), 4'h5};
        end
        // comm 2.5 or 2, PCI 5
        4'hd: begin
          if (lo <= 3'h4)
            s = '{1'b1, 5'h05, 5'(5'h06 + k), 4'h5};
          else if (lo == 3'h5)
            s = '{1'b1, 5'h04, 5'h06, 4'h5};
          else if (lo == 3'h6)
            s = '{1'b1, 5'h04, 5'h08, 4'h5};
        end
        4'he: begin
          if (lo <= 3'h4)
            s = '{1'b1, 5'h06, 5'(5'h07 + k), 4'h6};
        end
        default: s = '0;
      endcase
    end else begin
      case (code[6:3])
        4'h8: begin
          if (lo >= 3'h2 && lo <= 3'h6)
            s = '{1'b1, 5'h06,
                  5'(k + ((lo >= 3'h5) ? 5'h07 : 5'h05)), 4'h8};
        end
        // comm 2, PCI 6 or 8
        4'ha: begin
          if (lo <= 3'h4)
            s = '{1'b1, 5'h04, 5'(5'h04 + k), 4'h6};
          else
            s = '{1'b1, 5'h04, k, 4'h8};
        end
        default: s = '0;
      endcase
    end
    return s;
  endfunction

  function automatic logic [5:0] pci_ratio(
    input logic       range,
    input logic [3:0] field
  );
    logic [5:0] r;
    r = '0;
    if (!range) begin
      // ratio = (field + 1) / 2, held in half steps
      r = {1'b1, 5'({1'b0, field} + 5'h01)};
    end else begin
      case (field)
        4'h3:    r = {1'b1, 5'h08};
        4'h5:    r = {1'b1, 5'h0c};
        4'h7:    r = {1'b1, 5'h10};
        4'h9:    r = {1'b1, 5'h0a};
        4'hb:    r = {1'b1, 5'h0c};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  function automatic logic [31:0] read_mux(
    input clock_mode_pkg::state_s s,
    input logic [3:0]             a
  );
    logic [31:0] v;
    v = '0;
    case (a)
      `REG_CLOCK_CTRL: v[3:0] = s.div_field;
      `REG_MODE: begin
        v[`MODE_CODE_LSB +: 7]  = s.code;
        v[`MODE_RANGE_BIT]      = s.range;
        v[`MODE_VALID_BIT]      = s.cfg.valid;
        v[`MODE_LOADED_BIT]     = s.loaded;
      end
      `REG_FACTORS: begin
        v[`FACT_COMM_LSB +: 5]  = s.cfg.comm_x2;
        v[`FACT_CORE_LSB +: 5]  = s.cfg.core_x2;
        v[`FACT_PDIV_LSB +: 4]  = s.cfg.pci_div;
      end
      `REG_RATIO: begin
        v[`RATIO_LSB +: 5]      = s.ratio_x2;
        v[`RATIO_VALID_BIT]     = s.ratio_valid;
      end
      default: v = '0;
    endcase
    return v;
  endfunction

  always_comb begin
    logic [5:0] rat;
    rat    = '0;
    next_q = q;

    // capture once after hard reset, frozen afterwards
    if (!q.loaded) begin
      next_q.loaded = 1'b1;
      // upper nibble from config word, low bits from pins
      next_q.code   = {hard_reset_config_word[`CFG_WORD_MODE_MSB:
                                              `CFG_WORD_MODE_LSB],
                       mode_config_pins};
      // range select chooses the decode table
      next_q.range  = pci_range_select;
      next_q.cfg    = decode_mode(pci_range_select, next_q.code);
      // reserved codes give zero factors and a flag
      next_q.reserved = ~next_q.cfg.valid;
      // core ratios 2.5 and 3.5 stretch the tick spacing
      if (next_q.cfg.core_x2 == `CORE_X2_2P5)
        next_q.spacing = clock_mode_pkg::SPACE_TENTH;
      else if (next_q.cfg.core_x2 == `CORE_X2_3P5)
        next_q.spacing = clock_mode_pkg::SPACE_FOURTEENTH;
      else
        next_q.spacing = clock_mode_pkg::SPACE_QUARTER;
    end

    // Division field write steers the ratio
    if (wr_en && addr == `REG_CLOCK_CTRL)
      next_q.div_field = wdata[3:0];

    rat                = pci_ratio(q.range, q.div_field);
    next_q.ratio_valid = rat[5];
    next_q.ratio_x2    = rat[4:0];

    // Read data stands only in the cycle after the strobe
    next_q.rdata = rd_en ? read_mux(q, addr) : '0;

    // one reference period, four ticks inside it
    next_q.cnt = (q.cnt == 16'(LAST)) ? '0 : 16'(q.cnt + 16'h0001);
    // first at rising edge, third at falling edge
    next_q.first = (next_q.cnt == '0);
    next_q.third = (next_q.cnt == 16'(HALF));
    case (q.spacing)
      clock_mode_pkg::SPACE_TENTH: begin
        next_q.second = (next_q.cnt == 16'(D2));
        next_q.fourth = (next_q.cnt == 16'(D4));
      end
      clock_mode_pkg::SPACE_FOURTEENTH: begin
        next_q.second = (next_q.cnt == 16'(F2));
        next_q.fourth = (next_q.cnt == 16'(F4));
      end
      default: begin
        next_q.second = (next_q.cnt == 16'(Q2));
        next_q.fourth = (next_q.cnt == 16'(Q4));
      end
    endcase
    // bus launch only with the rising edge
    next_q.bus_launch = next_q.first;
    // memory controller strobe on any tick
    next_q.mem_tick = next_q.first | next_q.second |
                      next_q.third | next_q.fourth;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q         <= '0;
      q.div_field <= `CLOCK_CTRL_RESET;
      q.spacing <= clock_mode_pkg::SPACE_QUARTER;
      q.cnt     <= 16'(LAST);
    end else begin
      q <= next_q;
    end
  end

  assign comm_proc_mult_x2 = q.cfg.comm_x2;
  assign core_mult_x2      = q.cfg.core_x2;
  assign pci_div           = q.cfg.pci_div;
  assign mode_reserved     = q.reserved;
  assign config_loaded     = q.loaded;
  assign pci_ratio_x2      = q.ratio_x2;
  assign pci_ratio_valid   = q.ratio_valid;
  assign first_tick        = q.first;
  assign second_tick       = q.second;
  assign third_tick        = q.third;
  assign fourth_tick       = q.fourth;
  assign bus_launch        = q.bus_launch;
  assign mem_tick          = q.mem_tick;
  assign rdata             = q.rdata;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Local copies keep every delay a plain int of this module
  localparam int PERIOD = REF_DIV;
  localparam int HALF_D = HALF;
  localparam int TQ2    = Q2;
  localparam int TQ4    = Q4;
  localparam int TT2    = D2;
  localparam int TT4    = D4;
  localparam int TF2    = F2;
  localparam int TF4    = F4;

  a_tick_period: assert property (
    first_tick |-> ##PERIOD first_tick)
    else $error("first tick period wrong");
  a_third_at_half: assert property (
    first_tick |-> ##HALF_D third_tick)
    else $error("third tick not at half period");
  a_quarter_pos: assert property (
    first_tick && q.spacing == clock_mode_pkg::SPACE_QUARTER
    |-> ##TQ2 second_tick)
    else $error("second tick not at quarter");
  a_tenth_pos: assert property (
    first_tick && q.spacing == clock_mode_pkg::SPACE_TENTH
    |-> ##TT2 second_tick)
    else $error("second tick not at three tenths");
  a_fourteenth_pos: assert property (
    first_tick && q.spacing == clock_mode_pkg::SPACE_FOURTEENTH
    |-> ##TF4 fourth_tick)
    else $error("fourth tick not at eleven fourteenths");
  a_quarter_fourth: assert property (
    first_tick && q.spacing == clock_mode_pkg::SPACE_QUARTER
    |-> ##TQ4 fourth_tick)
    else $error("fourth tick not at three quarters");
  a_tenth_fourth: assert property (
    first_tick && q.spacing == clock_mode_pkg::SPACE_TENTH
    |-> ##TT4 fourth_tick)
    else $error("fourth tick not at eight tenths");
  a_fourteenth_second: assert property (
    first_tick && q.spacing == clock_mode_pkg::SPACE_FOURTEENTH
    |-> ##TF2 second_tick)
    else $error("second tick not at four fourteenths");
  a_mem_any_tick: assert property (
    mem_tick == (first_tick | second_tick | third_tick | fourth_tick))
    else $error("memory strobe not tied to ticks");
  a_bus_on_rise: assert property (
    bus_launch == first_tick && !(bus_launch && third_tick))
    else $error("bus launch off the rising edge");
  a_config_held: assert property (
    config_loaded && $past(config_loaded) |->
    $stable(core_mult_x2) && $stable(comm_proc_mult_x2) &&
    $stable(pci_div))
    else $error("decoded setting changed after load");
  a_reserved_zero: assert property (
    mode_reserved |-> core_mult_x2 == 5'h00 && pci_div == 4'h0)
    else $error("reserved code produced a setting");
  a_ratio_range0: assert property (
    config_loaded && !q.range && wr_en && addr == `REG_CLOCK_CTRL
    |=> ##1 pci_ratio_x2 == 5'($past(wdata[3:0], 2) + 5'h01))
    else $error("range 0 ratio wrong");
  a_ratio_range1: assert property (
    config_loaded && q.range && wr_en && addr == `REG_CLOCK_CTRL &&
    wdata[3:0] == 4'h9 |=> ##1 pci_ratio_x2 == 5'h0a && pci_ratio_valid)
    else $error("range 1 ratio wrong");
  // Read data shows the factors held at the strobe edge
  a_read_next: assert property (
    rd_en && addr == `REG_FACTORS |=>
    rdata[`FACT_CORE_LSB +: 5] == $past(core_mult_x2))
    else $error("factor read mismatch");
  // Sampled reset gate: the release edge itself still sees reset
  a_code_capture: assert property (
    reset_n && !config_loaded |=>
    q.code[2:0] == $past(mode_config_pins) &&
    q.code[6:3] == $past(hard_reset_config_word[`CFG_WORD_MODE_MSB:
                                                `CFG_WORD_MODE_LSB]))
    else $error("mode code not captured at release");

  c_reserved: cover property (config_loaded && mode_reserved);
  c_range1: cover property (config_loaded && q.range && q.cfg.valid);
  c_tenth: cover property (second_tick &&
    q.spacing == clock_mode_pkg::SPACE_TENTH);
  c_div_write: cover property (wr_en && addr == `REG_CLOCK_CTRL);
  c_fourteenth: cover property (fourth_tick &&
    q.spacing == clock_mode_pkg::SPACE_FOURTEENTH);

endmodule

// file: test/cfg_source.sv
// Reset configuration source facing the mode inputs
`timescale 1ns/10ps
module cfg_source (
  input  wire logic [6:0]  code,
  input  wire logic        range_sel,
  input  wire logic [27:0] filler,
  output logic      [31:0] hard_reset_config_word,
  output logic      [2:0]  mode_config_pins,
  output logic             pci_range_select
);
  // nibble on top word bits
  // Random filler shows the low word bits are ignored
  assign hard_reset_config_word = {code[6:3], filler};
  assign mode_config_pins = code[2:0];
  assign pci_range_select = range_sel;
endmodule

// file: test/clock_mode_decode_and_ticks_test.sv
// Self-checking bench for the clock mode decoder
`timescale 1ns/10ps
module clock_mode_decode_and_ticks_test;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        rd_pend = 1'b0;
  logic [6:0]  code = 7'h0;
  logic        range_sel = 1'b0;
  logic [27:0] filler = 28'h0;
  logic [31:0] seed = 32'h9e77;
  logic [31:0] word;
  logic [2:0]  pins;
  logic        prange;
  logic [31:0] rdata;
  logic        first_tick;
  logic        second_tick;
  logic        third_tick;
  logic        fourth_tick;
  logic        bus_launch;
  logic        mem_tick;
  logic [4:0]  comm;
  logic [4:0]  rx;
  logic        rv;
  logic [4:0]  core;
  logic [3:0]  pdiv;
  logic        reserved;
  logic        loaded;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [31:0] exp_q[$];

  always #2 clk_sys = ~clk_sys;

  cfg_source u_cfg_source (
    .code                   (code),
    .range_sel              (range_sel),
    .filler                 (filler),
    .hard_reset_config_word (word),
    .mode_config_pins       (pins),
    .pci_range_select       (prange)
  );

  clock_mode_decode_and_ticks #(.REF_DIV(140)) u_clock_mode_decode_and_ticks (
    .clk_sys                (clk_sys),
    .reset_n                (reset_n),
    .hard_reset_config_word (word),
    .mode_config_pins       (pins),
    .pci_range_select       (prange),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr_en                  (wr_en),
    .rd_en                  (rd_en),
    .rdata                  (rdata),
    .first_tick             (first_tick),
    .second_tick            (second_tick),
    .third_tick             (third_tick),
    .fourth_tick            (fourth_tick),
    .bus_launch             (bus_launch),
    .mem_tick               (mem_tick),
    .comm_proc_mult_x2      (comm),
    .core_mult_x2           (core),
    .pci_div                (pdiv),
    .mode_reserved          (reserved),
    .config_loaded          (loaded),
    .pci_ratio_x2           (rx),
    .pci_ratio_valid        (rv)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] ratio_exp(input logic r,
                                            input logic [3:0] f);
    logic [4:0] x;
    x = 5'h00;
    if (!r) x = {1'b0, f} + 5'h01;
    else case (f)
      4'h3: x = 5'h08;
      4'h5: x = 5'h0c;
      4'h7: x = 5'h10;
      4'h9: x = 5'h0a;
      4'hb: x = 5'h0c;
      default: x = 5'h00;
    endcase
    return {23'h0, x != 5'h00, 3'h0, x};
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobes get a gap so no signal is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    if (rd_pend && exp_q.size() > 0) begin
      check("rdata", rdata, exp_q.pop_front());
    end
    rd_pend <= rd_en;
  end

  task automatic ticks(input logic [4:0] co);
    int n;
    int p2;
    int p3;
    int p4;
    int p1;
    int mc;
    int bc;
    n = 0;
    p1 = 0;
    p2 = 0;
    p3 = 0;
    p4 = 0;
    mc = 0;
    bc = 0;
    @(negedge clk_sys);
    while (first_tick !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 300) begin
        mismatches++;
        end_of_test();
      end
    end
    for (int i = 1; i <= 140; i++) begin
      @(negedge clk_sys);
      if (second_tick === 1'b1) p2 = i;
      if (third_tick === 1'b1) p3 = i;
      if (fourth_tick === 1'b1) p4 = i;
      if (first_tick === 1'b1 && p1 == 0) p1 = i;
      if (mem_tick === 1'b1 && i < 140) mc++;
      if (bus_launch === 1'b1) bc++;
    end
    check("second", p2, co == 5'h05 ? 42 : co == 5'h07 ? 40 : 35);
    check("third", p3, 70);
    check("fourth", p4, co == 5'h05 ? 112 : co == 5'h07 ? 110 : 105);
    check("period", p1, 140);
    check("mem", mc, 3);
    check("bus", bc, 1);
    @(posedge clk_sys);
  endtask

  task automatic run_mode(input logic r, input logic [6:0] c,
                          input logic [4:0] cp, input logic [4:0] co,
                          input logic [3:0] pd);
    logic        res;
    logic [31:0] f;
    res = (cp == 5'h00);
    seed = xs(seed);
    reset_n <= 1'b0;
    range_sel <= r;
    code <= c;
    filler <= seed[27:0];
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    code <= ~c;
    range_sel <= ~r;
    @(negedge clk_sys);
    check("ports", {reserved, loaded, comm, core, pdiv},
          {res, 1'b1, cp, co, pd});
    @(posedge clk_sys);
    rd(4'h0, 32'h3);
    rd(4'h8, {12'h0, pd, 3'h0, co, 3'h0, cp});
    wr(4'h4, 32'hffffffff);
    rd(4'h4, {21'h0, 1'b1, ~res, r, 1'b0, c});
    rd(4'h2, 32'h0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      f = {seed[31:4], 4'(i)};
      wr(4'h0, f);
      rd(4'h0, {28'h0, f[3:0]});
      rd(4'hc, ratio_exp(r, f[3:0]));
      check("ratio", {23'h0, rv, 3'h0, rx}, ratio_exp(r, f[3:0]));
    end
    ticks(co);
  endtask

  initial begin
    run_mode(1'b0, 7'h00, 5'h04, 5'h05, 4'h2);
    run_mode(1'b0, 7'h01, 5'h04, 5'h06, 4'h2);
    run_mode(1'b0, 7'h0b, 5'h06, 5'h10, 4'h3);
    run_mode(1'b0, 7'h10, 5'h08, 5'h0a, 4'h4);
    run_mode(1'b0, 7'h15, 5'h08, 5'h0b, 4'h6);
    run_mode(1'b0, 7'h1a, 5'h0a, 5'h0e, 4'h5);
    run_mode(1'b0, 7'h68, 5'h05, 5'h06, 4'h5);
    run_mode(1'b0, 7'h6e, 5'h04, 5'h08, 4'h5);
    run_mode(1'b0, 7'h70, 5'h06, 5'h07, 4'h6);
    run_mode(1'b0, 7'h74, 5'h06, 5'h0b, 4'h6);
    run_mode(1'b1, 7'h46, 5'h06, 5'h0d, 4'h8);
    run_mode(1'b1, 7'h42, 5'h06, 5'h07, 4'h8);
    run_mode(1'b1, 7'h51, 5'h04, 5'h05, 4'h6);
    run_mode(1'b1, 7'h57, 5'h04, 5'h07, 4'h8);
    run_mode(1'b0, 7'h20, 5'h00, 5'h00, 4'h0);
    run_mode(1'b1, 7'h00, 5'h00, 5'h00, 4'h0);
    repeat (3) @(posedge clk_sys);
    end_of_test();
  end
endmodule
